// ---- rtl/strap_config_defines.vh ----
// Purpose: Offsets, field positions and reset values for the strap loader
// Assumes: 32-bit APB, one register per aligned word
// Notes:   Included by its bare name, definitions only
`ifndef STRAP_CONFIG_DEFINES_VH
`define STRAP_CONFIG_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PORT_CFG_BASE_OFS 8'h00
`define CTRL_OFS 8'h20
`define STATUS_OFS 8'h24
`define STRAP_RAW_OFS 8'h28
`define ADDR_INDEX_MSB 7

// ----------------------------------------------------------------
// Port configuration register fields
// ----------------------------------------------------------------
`define PCFG_XOVER_BIT 0
`define PCFG_CFG_LSB 1
`define PCFG_CFG_MSB 3
`define PCFG_SLEW_LSB 4
`define PCFG_SLEW_MSB 5
`define PCFG_WIDTH 6
`define PCFG_RESET 6'h00

// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define CTRL_SWRST_BIT 0
`define STAT_BASE_LSB 0
`define STAT_BASE_MSB 4
`define STAT_MODE_LSB 5
`define STAT_MODE_MSB 6
`define STAT_MODE_ERR_BIT 7
`define STAT_LOADED_BIT 8

// ----------------------------------------------------------------
// Interface mode codes and address layout
// ----------------------------------------------------------------
`define MODE_SMII 2'h1
`define MODE_SSSMII 2'h2
`define PORT_COUNT 8
`define BASE_LOW_ZERO 3'h0
`define STRAP_WIDTH 11
`define STRAP_RESET 11'h000
`define SYNC_SETTLE 3'h4

`endif

// ---- rtl/strap_config_latch.v ----
// Purpose: Samples board straps at reset release, loads per-port defaults
//          and serves them to the management host over APB.
// Assumes: One 20 MHz clock, straps steady around reset release.
// Notes:   Software reset is a one-cycle self-clearing pulse that reloads
//          the straps; the register file stays writable afterwards.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "strap_config_defines.vh"

// Contract
// (RULE1) Internal reset is hardware OR software reset
// (RULE2) Hardware reset forces all outputs inactive
// (RULE3) Base address from two straps, low bits zero
// (RULE4) Port answers at base plus port index
// (RULE5) Mode 01 SMII, 10 SS-SMII, others reserved
// (RULE6) Auto crossover strap loads every port default
// (RULE7) Host may read and overwrite defaults afterwards
// (RULE8) Auto crossover high selects automatic crossover everywhere
// (RULE9) Auto crossover low follows manual crossover pin
// (RULE10) Three global strap pins load every port
// (RULE11) Edge-rate straps load two-bit slew field, writable
// (RULE12) Capture straps once at release, hold until reset
// (RULE13) Board holds straps stable across reset release
module strap_config_latch (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire auto_crossover_strap,
    input wire manual_crossover_pin,
    input wire tx_edge_rate_strap0,
    input wire tx_edge_rate_strap1,
    input wire global_cfg_strap1,
    input wire global_cfg_strap2,
    input wire global_cfg_strap3,
    input wire base_addr_strap3,
    input wire base_addr_strap4,
    input wire iface_select_bit0,
    input wire iface_select_bit1,
    input wire [4:0] mgmt_addr,
    output reg [7:0] port_addr_hit,
    output reg [4:0] mgmt_base_addr,
    output reg smii_mode,
    output reg sssmii_mode,
    output reg iface_mode_err,
    output reg [7:0] port_auto_xover,
    output reg [7:0] port_manual_crossover_pin,
    output reg [23:0] port_global_cfg,
    output reg [15:0] port_tx_slew,
    output reg core_reset
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Port index matched by a management address, 8 when none
    function [3:0] port_of_addr;
        input [4:0] addr;
        input [4:0] base;
        begin
            if (addr[4:3] == base[4:3]) begin
                port_of_addr = {1'b0, addr[2:0]};
            end else begin
                port_of_addr = 4'h8;
            end
        end
    endfunction

    // Flags an aligned APB address inside the per-port register block
    function is_port_reg;
        input [7:0] addr;
        begin
            is_port_reg = (addr[1:0] == 2'h0) &&
                (addr < (`PORT_CFG_BASE_OFS + 8'h20));
        end
    endfunction

    // ------------------------------------------------------------
    // Strap input synchroniser
    // ------------------------------------------------------------
    // Bit order: mode1..0, addr4..3, cfg3..1, slew1..0, manual, auto
    wire [10:0] strap_pins;
    reg [10:0] strap_s1_q;
    reg [10:0] strap_s2_q;
    reg [10:0] strap_s3_q;
    reg [10:0] strap_lvl_q;
    reg [10:0] strap_lvl_d;
    integer i;

    assign strap_pins = {iface_select_bit1, iface_select_bit0,
        base_addr_strap4, base_addr_strap3,
        global_cfg_strap3, global_cfg_strap2, global_cfg_strap1,
        tx_edge_rate_strap1, tx_edge_rate_strap0,
        manual_crossover_pin, auto_crossover_strap};

    // A bit counts only once stages two and three agree
    always @* begin
        strap_lvl_d = strap_lvl_q;
        for (i = 0; i < `STRAP_WIDTH; i = i + 1) begin
            if (strap_s2_q[i] == strap_s3_q[i]) begin
                strap_lvl_d[i] = strap_s3_q[i];
            end
        end
    end

    // Three stages, first read only by the second
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s1_q <= `STRAP_RESET;
            strap_s2_q <= `STRAP_RESET;
            strap_s3_q <= `STRAP_RESET;
            strap_lvl_q <= `STRAP_RESET;
        end else begin
            strap_s1_q <= strap_pins;
            strap_s2_q <= strap_s1_q;
            strap_s3_q <= strap_s2_q;
            strap_lvl_q <= strap_lvl_d;
        end
    end

    // ------------------------------------------------------------
    // Reset combination and capture control
    // ------------------------------------------------------------
    reg swrst_q;
    reg load_pend_q;
    reg [2:0] settle_q;
    reg loaded_q;
    wire int_reset;
    wire capture;
    wire apb_wr;
    wire apb_rd;

    // Hardware reset is the async term, software bit the sync one
    assign int_reset = swrst_q; // see (RULE1)
    // Wait for the sync chain to fill so a pre-reset value is not taken
    assign capture = load_pend_q && !int_reset &&
        (settle_q == `SYNC_SETTLE);
    assign apb_wr = psel && penable && pready && pwrite;
    assign apb_rd = psel && !penable && !pwrite;

    // Software reset bit self-clears after one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swrst_q <= 1'b0;
        end else begin
            swrst_q <= apb_wr && (paddr == `CTRL_OFS) &&
                pwdata[`CTRL_SWRST_BIT] && !swrst_q;
        end
    end

    // One capture per release, then held until the next reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_pend_q <= 1'b1;
            settle_q <= 3'h0;
            loaded_q <= 1'b0;
        end else if (int_reset) begin
            load_pend_q <= 1'b1; // see (RULE1)
            settle_q <= `SYNC_SETTLE;
            loaded_q <= 1'b0;
        end else if (capture) begin
            load_pend_q <= 1'b0; // see (RULE12)
            loaded_q <= 1'b1;
        end else if (load_pend_q) begin
            settle_q <= settle_q + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Global straps: base address and interface mode
    // ------------------------------------------------------------
    reg [1:0] base_hi_q;
    reg [1:0] mode_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_hi_q <= 2'h0;
            mode_q <= 2'h0;
        end else if (capture) begin
            base_hi_q <= strap_lvl_q[8:7]; // see (RULE12)
            mode_q <= strap_lvl_q[10:9]; // see (RULE5)
        end
    end

    // ------------------------------------------------------------
    // Per-port configuration registers
    // ------------------------------------------------------------
    wire [5:0] strap_default;
    wire [47:0] pcfg_flat;

    // Default word shared by every port
    assign strap_default = {strap_lvl_q[3:2], strap_lvl_q[6:4],
        strap_lvl_q[0]};

    genvar p;
    generate
        for (p = 0; p < `PORT_COUNT; p = p + 1) begin : g_port
            reg [5:0] pcfg_q;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pcfg_q <= `PCFG_RESET;
                end else if (capture) begin
                    // Straps give the defaults for all ports
                    pcfg_q <= strap_default; // see (RULE6) (RULE10)
                end else if (apb_wr && loaded_q && is_port_reg(paddr) &&
                    (paddr[4:2] == p)) begin
                    // Host overwrite once loading is done
                    pcfg_q <= pwdata[5:0]; // see (RULE7) (RULE11)
                end
            end
            assign pcfg_flat[p*6 +: 6] = pcfg_q;
        end
    endgenerate

    // ------------------------------------------------------------
    // Registered outputs toward the port logic
    // ------------------------------------------------------------
    reg [3:0] hit_port;
    reg [7:0] hit_d;
    reg [7:0] xover_d;
    reg [7:0] manual_crossover_pin_d;
    reg [23:0] cfg_d;
    reg [15:0] slew_d;
    integer k;

    // Address match and crossover choice per port
    always @* begin
        hit_d = 8'h00;
        xover_d = 8'h00;
        manual_crossover_pin_d = 8'h00;
        cfg_d = 24'h000000;
        slew_d = 16'h0000;
        hit_port = port_of_addr(mgmt_addr, {base_hi_q, `BASE_LOW_ZERO});
        for (k = 0; k < `PORT_COUNT; k = k + 1) begin
            hit_d[k] = loaded_q && (hit_port == k); // see (RULE4)
            xover_d[k] = pcfg_flat[k*6];
            // Auto forces the manual crossover output high; else the manual pin rules
            manual_crossover_pin_d[k] = pcfg_flat[k*6] ? 1'b1 :
                strap_lvl_q[1]; // see (RULE8) (RULE9)
            cfg_d[k*3 +: 3] = pcfg_flat[k*6+1 +: 3];
            slew_d[k*2 +: 2] = pcfg_flat[k*6+4 +: 2]; // see (RULE11)
        end
    end

    // All outputs held inactive through hardware reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_addr_hit <= 8'h00; // see (RULE2)
            mgmt_base_addr <= 5'h00;
            smii_mode <= 1'b0;
            sssmii_mode <= 1'b0;
            iface_mode_err <= 1'b0;
            port_auto_xover <= 8'h00;
            port_manual_crossover_pin <= 8'h00;
            port_global_cfg <= 24'h000000;
            port_tx_slew <= 16'h0000;
            core_reset <= 1'b0;
        end else begin
            port_addr_hit <= hit_d;
            mgmt_base_addr <= {base_hi_q, `BASE_LOW_ZERO}; // see (RULE3)
            smii_mode <= loaded_q && (mode_q == `MODE_SMII); // see (RULE5)
            sssmii_mode <= loaded_q && (mode_q == `MODE_SSSMII);
            // Reserved codes flagged, one mode for all ports
            iface_mode_err <= loaded_q && (mode_q != `MODE_SMII) &&
                (mode_q != `MODE_SSSMII);
            port_auto_xover <= xover_d;
            port_manual_crossover_pin <= manual_crossover_pin_d;
            port_global_cfg <= cfg_d;
            port_tx_slew <= slew_d;
            core_reset <= int_reset || load_pend_q; // see (RULE1)
        end
    end

    // ------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------
    reg [31:0] rdata_d;
    reg err_d;

    // Read mux and unmapped detection, evaluated in setup phase
    always @* begin
        rdata_d = 32'h00000000;
        err_d = 1'b0;
        if (is_port_reg(paddr)) begin
            rdata_d[5:0] = pcfg_flat[paddr[4:2]*6 +: 6]; // see (RULE7)
        end else if (paddr == `CTRL_OFS) begin
            rdata_d[`CTRL_SWRST_BIT] = swrst_q;
        end else if (paddr == `STATUS_OFS) begin
            rdata_d[`STAT_BASE_MSB:`STAT_BASE_LSB] =
                {base_hi_q, `BASE_LOW_ZERO};
            rdata_d[`STAT_MODE_MSB:`STAT_MODE_LSB] = mode_q;
            rdata_d[`STAT_MODE_ERR_BIT] = (mode_q != `MODE_SMII) &&
                (mode_q != `MODE_SSSMII);
            rdata_d[`STAT_LOADED_BIT] = loaded_q;
        end else if (paddr == `STRAP_RAW_OFS) begin
            rdata_d[10:0] = strap_lvl_q;
        end else begin
            err_d = 1'b1;
        end
    end

    // Answer one cycle after setup; data held until next read setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                pslverr <= err_d;
            end else begin
                pslverr <= 1'b0;
            end
            if (apb_rd) begin
                prdata <= rdata_d;
            end
        end
    end

endmodule

// ---- verification/strap_board.sv ----
// Purpose: Board strap resistors seen by the strap loader
// Assumes: Straps are set by the bench, only at a clock edge
// Notes:   Bit order: mode1,mode0,addr4,addr3,cfg3..1,slew1,slew0,man,auto
`timescale 1ns/1ps
module strap_board (
    input wire pclk,
    input wire [10:0] level,
    output reg [10:0] pins
);
    // Resistors never glitch: pins move once per edge, then stand
    always @(posedge pclk) begin
        pins <= level;
    end
endmodule

// ---- verification/strap_config_latch_asserts.sv ----
// Purpose: Port-level checks of the strap loader
// Assumes: One pclk domain, presetn async active low
// Notes:   Bound to every strap_config_latch instance
`timescale 1ns/1ps
`include "strap_config_defines.vh"
module strap_config_latch_asserts (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [4:0] mgmt_addr,
    input wire [7:0] port_addr_hit,
    input wire [4:0] mgmt_base_addr,
    input wire smii_mode,
    input wire sssmii_mode,
    input wire iface_mode_err,
    input wire [7:0] port_auto_xover,
    input wire [7:0] port_manual_crossover_pin,
    input wire [23:0] port_global_cfg,
    input wire [15:0] port_tx_slew,
    input wire core_reset
);
    // Expected hit mask; wraps past 31 so it never matches
    function automatic [7:0] hit_of(input [4:0] a, input [4:0] b);
        reg [4:0] d;
        begin
            d = a - b;
            hit_of = (d < 5'h08) ? (8'h01 << d[2:0]) : 8'h00;
        end
    endfunction
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_reset_quiet: assert property (disable iff (1'b0) !presetn |->
        ~|{pready, pslverr, core_reset, smii_mode, sssmii_mode, prdata,
        iface_mode_err, port_addr_hit, mgmt_base_addr, port_auto_xover,
        port_manual_crossover_pin, port_global_cfg, port_tx_slew})
        else $error("output active in reset");
    a_base_low: assert property (mgmt_base_addr[2:0] == 3'h0)
        else $error("base low bits set");
    a_mode_onehot: assert property (!core_reset ##1 !core_reset |->
        $onehot({smii_mode, sssmii_mode, iface_mode_err}))
        else $error("mode outputs not one-hot");
    a_port_hit: assert property (!core_reset [*3] |->
        port_addr_hit == hit_of($past(mgmt_addr), mgmt_base_addr))
        else $error("address hit wrong");
    a_straps_hold: assert property (!core_reset ##1 !core_reset |->
        $stable({mgmt_base_addr, smii_mode, sssmii_mode, iface_mode_err}))
        else $error("strap outputs moved");
    // Both outputs leave the same register on the same edge
    a_auto_manual_crossover_pin: assert property (!core_reset |->
        ((port_manual_crossover_pin | ~port_auto_xover) == 8'hFF))
        else $error("auto crossover not forcing manual_crossover_pin");
    a_pready_once: assert property (psel && !penable |=>
        pready ##1 !pready) else $error("pready not one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_swreset: assert property (psel && penable && pready && pwrite
        && paddr == `CTRL_OFS && pwdata[0] |-> ##[1:3] core_reset)
        else $error("software reset ignored");
    a_release_load: assert property ($rose(presetn) |=>
        core_reset ##[1:7] !core_reset) else $error("load not on time");
    c_hit: cover property (|port_addr_hit);
    c_err: cover property (pslverr);
    c_sw: cover property (psel && penable && pready && pwrite &&
        paddr == `CTRL_OFS ##[1:3] core_reset ##[1:8] !core_reset);
endmodule

bind strap_config_latch strap_config_latch_asserts u_chk (.*);

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the strap loader
// Assumes: APB slave answers one cycle after setup
// Notes:   Each scenario task drives and judges its own case
`timescale 1ns/1ps
`include "strap_config_defines.vh"
module tb_top;
    reg pclk = 1'b0;
    reg presetn = 1'b1; // Lowered at the first edge, avoids X at time 0
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg [10:0] level = 11'h000;
    reg [4:0] mgmt_addr = 5'h00;
    wire [31:0] prdata;
    wire pready, pslverr, smii_mode, sssmii_mode, iface_mode_err, core_reset;
    wire [10:0] pins;
    wire [7:0] port_addr_hit, port_auto_xover, port_manual_crossover_pin;
    wire [4:0] mgmt_base_addr;
    wire [23:0] port_global_cfg;
    wire [15:0] port_tx_slew;
    integer mismatches = 0;
    integer tests_run = 0;
    integer k;
    reg [31:0] rd;
    reg err;
    // Last pattern leaves auto off for the manual pin case
    localparam [43:0] strap_pats = {11'h4A6, 11'h183, 11'h77C, 11'h259};
    strap_board board (.pclk(pclk), .level(level), .pins(pins));
    strap_config_latch uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .auto_crossover_strap(pins[0]), .manual_crossover_pin(pins[1]),
        .tx_edge_rate_strap0(pins[2]), .tx_edge_rate_strap1(pins[3]),
        .global_cfg_strap1(pins[4]), .global_cfg_strap2(pins[5]),
        .global_cfg_strap3(pins[6]), .base_addr_strap3(pins[7]),
        .base_addr_strap4(pins[8]), .iface_select_bit0(pins[9]),
        .iface_select_bit1(pins[10]), .mgmt_addr(mgmt_addr),
        .port_addr_hit(port_addr_hit), .mgmt_base_addr(mgmt_base_addr),
        .smii_mode(smii_mode), .sssmii_mode(sssmii_mode),
        .iface_mode_err(iface_mode_err), .port_auto_xover(port_auto_xover),
        .port_manual_crossover_pin(port_manual_crossover_pin), .port_global_cfg(port_global_cfg),
        .port_tx_slew(port_tx_slew), .core_reset(core_reset));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    initial begin
        forever #25 pclk = ~pclk;
    end
    task check(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, mismatches);
            if (mismatches == 0 && tests_run > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    // Request held until pready is seen at a rising edge
    task apb(input w, input [7:0] a, input [31:0] d);
        integer i;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            for (i = 0; i < 20 && pready !== 1'b1; i = i + 1) @(posedge pclk);
            if (i == 20) begin
                mismatches = mismatches + 1;
                report_and_stop;
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wait_loaded;
        integer i;
        begin
            repeat (2) @(posedge pclk);
            for (i = 0; i < 40 && core_reset !== 1'b0; i = i + 1)
                @(posedge pclk);
            if (i == 40) begin
                mismatches = mismatches + 1;
                report_and_stop;
            end
            #1;
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_load(input [10:0] s);
        reg [2:0] m;
        begin
            @(posedge pclk);
            level <= s;
            presetn <= 1'b0;
            repeat (12) @(posedge pclk);
            check({port_global_cfg, mgmt_base_addr, core_reset}, 0);
            presetn <= 1'b1;
            wait_loaded;
            m = (s[10:9] == `MODE_SMII) ? 3'h4 :
                (s[10:9] == `MODE_SSSMII) ? 3'h2 : 3'h1;
            check(mgmt_base_addr, {s[8:7], 3'h0});
            check({smii_mode, sssmii_mode, iface_mode_err}, m);
            check(port_auto_xover, {8{s[0]}});
            check(port_manual_crossover_pin, {8{s[0] | s[1]}});
            check(port_global_cfg, {8{s[6:4]}});
            check(port_tx_slew, {8{s[3:2]}});
            apb(1'b0, `STATUS_OFS, 32'h0);
            check(rd, {23'h1, m[0], s[10:7], 3'h0});
            $display("load test done");
        end
    endtask
    // Late strap changes: only the manual pin is followed
    task t_manual;
        begin
            @(posedge pclk);
            level <= 11'h524;
            repeat (8) @(posedge pclk);
            check(port_manual_crossover_pin, 8'h00);
            check(mgmt_base_addr, 5'h08);
            $display("manual test done");
        end
    endtask
    task t_hit;
        integer i;
        begin
            for (i = 0; i < 10; i = i + 1) begin
                @(posedge pclk);
                mgmt_addr <= 5'h07 + i[4:0];
                repeat (2) @(posedge pclk);
                check(port_addr_hit, (i > 0 && i < 9) ?
                    8'h01 << (i - 1) : 8'h00);
            end
            $display("hit test done");
        end
    endtask
    task t_overwrite;
        begin
            apb(1'b1, 8'h0C, 32'h2B);
            apb(1'b0, 8'h0C, 32'h0);
            check(rd, 32'h2B);
            check(port_auto_xover, 8'h08);
            check(port_manual_crossover_pin, 8'h08);
            check(port_global_cfg[11:9], 3'h5);
            check(port_tx_slew[7:6], 2'h2);
            apb(1'b0, 8'h3C, 32'h0);
            check(err, 32'h1);
            check(rd, 32'h0);
            $display("overwrite test done");
        end
    endtask
    task t_swreset;
        begin
            apb(1'b1, `CTRL_OFS, 32'h1);
            wait_loaded;
            check(mgmt_base_addr, 5'h10);
            check(port_auto_xover, 8'h00);
            check(port_global_cfg, {8{3'h2}});
            $display("software reset test done");
        end
    endtask
    initial begin
        for (k = 0; k < 4; k = k + 1) begin
            t_load(strap_pats[11 * k +: 11]);
        end
        t_manual;
        t_hit;
        t_overwrite;
        t_swreset;
        report_and_stop;
    end
endmodule
